// ### rtl/acf_clkdiv.sv
// Converter clock source select and prescaler, producing a one-cycle tick
`timescale 1ns/1ps
module acf_clkdiv
    import acf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic clk_sel,
    input wire logic [2:0] div_sel,
    // Crystal level, already synchronised
    input wire logic xtal_sync,
    // Converter clock tick
    output logic conv_clk_tick
);

    logic xtal_prev_ff;
    logic [ACF_DIV_CNT_W-1:0] cnt_ff;
    logic tick_ff;
    logic nxt_xtal_prev;
    logic [ACF_DIV_CNT_W-1:0] nxt_cnt;
    logic nxt_tick;
    logic src_tick;
    logic [ACF_DIV_CNT_W-1:0] limit;

    always_comb
    begin
        nxt_xtal_prev = xtal_sync;
        // Bus clock gives a source tick each cycle, crystal one per rising edge
        src_tick = clk_sel ? 1'b1 : (xtal_sync & ~xtal_prev_ff); // [RULE12]
        case (div_sel)
            3'h0: limit = 4'h0; // [RULE10]
            3'h1: limit = 4'h1;
            3'h2: limit = 4'h3;
            3'h3: limit = 4'h7;
            default: limit = 4'hF;
        endcase
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (src_tick)
        begin
            // Counter above a newly lowered limit wraps at once
            if (cnt_ff >= limit)
            begin
                nxt_cnt = '0;
                nxt_tick = 1'b1; // [RULE10]
            end
            else
            begin
                nxt_cnt = cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xtal_prev_ff <= 1'b0;
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            xtal_prev_ff <= nxt_xtal_prev;
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign conv_clk_tick = tick_ff;

endmodule : acf_clkdiv

// ### rtl/acf_format.sv
// Placement of a conversion result into the high and low data bytes
`timescale 1ns/1ps
module acf_format
    import acf_pkg::*;
(
    // Control
    input wire acf_fmt_e mode,
    // Result in and placed pair out
    input wire logic [9:0] result,
    output acf_result_s placed
);

    always_comb
    begin
        placed = '0;
        case (mode)
            ACF_FMT_TRUNC8:
            begin
                placed.high = 8'h00; // [RULE2]
                placed.low = result[9:2]; // [RULE2]
            end
            ACF_FMT_RIGHT:
            begin
                placed.high = {6'h00, result[9:8]}; // [RULE4]
                placed.low = result[7:0]; // [RULE4]
            end
            ACF_FMT_LEFT:
            begin
                placed.high = result[9:2]; // [RULE5]
                placed.low = {result[1:0], 6'h00}; // [RULE5]
            end
            ACF_FMT_SIGNED:
            begin
                placed.high = {~result[9], result[8:2]}; // [RULE6]
                placed.low = {result[1:0], 6'h00}; // [RULE6]
            end
            default:
            begin
                placed = '0;
            end
        endcase
    end

endmodule : acf_format

// ### rtl/acf_top.sv
// Converter result registers, clock control and AHB-Lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module acf_top
    import acf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter side
    input wire logic conv_done,
    input wire logic conv_single,
    input wire logic [9:0] conv_result,
    // Crystal reference pin and converter clock tick
    input wire logic crystal_reference_clock,
    output logic conv_clk_tick,
    // Interrupt
    output logic irq
);

    // Crystal synchroniser
    logic xtal_meta_ff;
    logic xtal_sync_ff;

    // Bus state
    acf_aphase_s aph_ff;
    acf_aphase_s nxt_aph;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic hreadyout_ff;
    logic hresp_ff;

    // Result state
    logic [7:0] high_ff;
    logic [7:0] low_ff;
    logic lock_ff;
    logic done_ff;
    logic [7:0] nxt_high;
    logic [7:0] nxt_low;
    logic nxt_lock;
    logic nxt_done;

    // Control and interrupt state
    acf_clk_ctrl_s ctrl_ff;
    acf_clk_ctrl_s nxt_ctrl;
    logic [ACF_IRQ_W-1:0] status_ff;
    logic [ACF_IRQ_W-1:0] mask_ff;
    logic [ACF_IRQ_W-1:0] nxt_status;
    logic [ACF_IRQ_W-1:0] nxt_mask;
    logic irq_ff;
    logic nxt_irq;

    // Decode terms
    logic accept;
    logic rd_high;
    logic rd_low;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic interlocked;
    logic store;
    logic lost;
    acf_result_s placed;

    // Two flops before anything looks at the crystal pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xtal_meta_ff <= 1'b0;
            xtal_sync_ff <= 1'b0;
        end
        else
        begin
            xtal_meta_ff <= crystal_reference_clock;
            xtal_sync_ff <= xtal_meta_ff;
        end
    end

    acf_clkdiv u_clkdiv (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_sel(ctrl_ff.clk_sel),
        .div_sel(ctrl_ff.div_sel),
        .xtal_sync(xtal_sync_ff),
        .conv_clk_tick(conv_clk_tick)
    );

    acf_format u_format (
        .mode(ctrl_ff.mode),
        .result(conv_result),
        .placed(placed)
    );

    // Bus decode: reads act in the address phase, writes in the data phase
    always_comb
    begin
        accept = hsel & hready & (htrans != ACF_HTRANS_IDLE) & htrans[1];
        rd_high = accept & ~hwrite & (haddr == ACF_ADDR_RESULT_HIGH);
        rd_low = accept & ~hwrite & (haddr == ACF_ADDR_RESULT_LOW);
        wr_ctrl = aph_ff.valid & aph_ff.write & (aph_ff.addr == ACF_ADDR_CLK_CTRL);
        wr_status = aph_ff.valid & aph_ff.write & (aph_ff.addr == ACF_ADDR_IRQ_STATUS);
        wr_mask = aph_ff.valid & aph_ff.write & (aph_ff.addr == ACF_ADDR_IRQ_MASK);
    end

    // Bus state next values
    always_comb
    begin
        nxt_aph.valid = accept;
        nxt_aph.write = hwrite;
        nxt_aph.addr = haddr;
        nxt_hrdata = '0;
        // Unmapped addresses read zero and writes to them are dropped
        if (accept && !hwrite)
        begin
            case (haddr)
                ACF_ADDR_RESULT_HIGH: nxt_hrdata = {24'h0, high_ff}; // [RULE1]
                ACF_ADDR_RESULT_LOW: nxt_hrdata = {24'h0, low_ff}; // [RULE1]
                ACF_ADDR_CLK_CTRL: nxt_hrdata = {24'h0, 6'h0, ctrl_ff.rsvd};
                ACF_ADDR_IRQ_STATUS: nxt_hrdata = {30'h0, status_ff};
                ACF_ADDR_IRQ_MASK: nxt_hrdata = {30'h0, mask_ff};
                ACF_ADDR_CONV_STATUS: nxt_hrdata = {30'h0, lock_ff, done_ff};
                default: nxt_hrdata = '0;
            endcase
            if (haddr == ACF_ADDR_CLK_CTRL)
            begin
                nxt_hrdata = {24'h0, ctrl_ff};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_ff <= '0;
            hrdata_ff <= '0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= ACF_HRESP_OKAY;
        end
        else
        begin
            aph_ff <= nxt_aph;
            hrdata_ff <= nxt_hrdata;
            // Zero wait states, always OKAY
            hreadyout_ff <= 1'b1;
            hresp_ff <= ACF_HRESP_OKAY;
        end
    end

    // Result bytes
    always_comb
    begin
        interlocked = (ctrl_ff.mode != ACF_FMT_TRUNC8);
        // Truncated format takes every completion, the others only
        // single-channel ones while the pair is not frozen; a high
        // read in the completion cycle already freezes the old pair
        store = conv_done &
            (~interlocked | (conv_single & ~lock_ff & ~rd_high)); // [RULE3] [RULE7] [RULE8]
        lost = conv_done & ~store; // [RULE8]
        nxt_high = high_ff;
        nxt_low = low_ff;
        // Writes never reach the data bytes
        if (store)
        begin
            nxt_high = placed.high; // [RULE1] [RULE14]
            nxt_low = placed.low; // [RULE1] [RULE9] [RULE14]
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_ff <= ACF_BYTE_RST; // [RULE9]
            low_ff <= ACF_BYTE_RST; // [RULE9]
        end
        else
        begin
            high_ff <= nxt_high;
            low_ff <= nxt_low;
        end
    end

    // Interlock and done flag
    always_comb
    begin
        nxt_lock = lock_ff;
        if (!interlocked)
        begin
            nxt_lock = 1'b0; // [RULE3]
        end
        else if (rd_high)
        begin
            nxt_lock = 1'b1; // [RULE8]
        end
        else if (rd_low)
        begin
            nxt_lock = 1'b0; // [RULE8]
        end
        nxt_done = done_ff;
        if (rd_low || wr_ctrl)
        begin
            nxt_done = 1'b0; // [RULE16] [RULE17]
        end
        // A completion in the clearing cycle is kept
        if (conv_done)
        begin
            nxt_done = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            lock_ff <= nxt_lock;
            done_ff <= nxt_done;
        end
    end

    // Control, interrupt status and mask
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl)
        begin
            nxt_ctrl = acf_clk_ctrl_s'(hwdata[7:0]); // [RULE10] [RULE12] [RULE14]
            nxt_ctrl.rsvd = 2'h0;
        end
        nxt_mask = mask_ff;
        if (wr_mask)
        begin
            nxt_mask = hwdata[ACF_IRQ_W-1:0];
        end
        nxt_status = status_ff;
        if (wr_status)
        begin
            nxt_status = status_ff & ~hwdata[ACF_IRQ_W-1:0];
        end
        // Set after clear so a same-cycle event wins
        if (store)
        begin
            nxt_status[ACF_IRQ_STORED_BIT] = 1'b1;
        end
        if (lost)
        begin
            nxt_status[ACF_IRQ_LOST_BIT] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= acf_clk_ctrl_s'(ACF_CLK_CTRL_RST); // [RULE12] [RULE15]
            mask_ff <= ACF_IRQ_RST;
            status_ff <= ACF_IRQ_RST;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
        end
    end

    // Level interrupt from the next status, so it moves with the flags
    always_comb
    begin
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign irq = irq_ff;

endmodule : acf_top

// ### shared/acf_pkg.sv
// Constants, types and register map of the converter result and clock block
//
// How it works
// RULE1 - Result held in two read-only bytes
// RULE2 - Truncated: bits 9..2 low, high zero
// RULE3 - Truncated: low refreshes always, no interlock
// RULE4 - Right: bits 9..8 high, 7..0 low
// RULE5 - Left: bits 9..2 high, 1..0 low top
// RULE6 - Signed left: result msb stored inverted
// RULE7 - Other formats update on single-channel completion
// RULE8 - High read freezes low until low read
// RULE9 - Data bytes ignore writes, reset to zero
// RULE10 - Prescaler divides by 1,2,4,8,16
// RULE11 - Software keeps converter clock 32 kHz-2 MHz
// RULE12 - Select bit: 1 bus clock, 0 crystal
// RULE13 - Crystal used only at 1 MHz or more
// RULE14 - Format field selects one of four placements
// RULE15 - Reset selects right-justified format
// RULE16 - Clock control write clears done flag
// RULE17 - Low byte read clears done flag
package acf_pkg;

    // Widths
    localparam int unsigned ACF_DATA_W = 32;
    localparam int unsigned ACF_RES_W = 10;
    localparam int unsigned ACF_BYTE_W = 8;
    localparam int unsigned ACF_IRQ_W = 2;
    localparam int unsigned ACF_DIV_CNT_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ACF_IDX_RESULT_HIGH = 8'h3D;
    localparam logic [7:0] ACF_IDX_RESULT_LOW = 8'h3E;
    localparam logic [7:0] ACF_IDX_CLK_CTRL = 8'h3F;
    localparam logic [7:0] ACF_IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] ACF_IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] ACF_IDX_CONV_STATUS = 8'h42;

    localparam logic [31:0] ACF_ADDR_RESULT_HIGH = {22'h0, ACF_IDX_RESULT_HIGH, 2'h0};
    localparam logic [31:0] ACF_ADDR_RESULT_LOW = {22'h0, ACF_IDX_RESULT_LOW, 2'h0};
    localparam logic [31:0] ACF_ADDR_CLK_CTRL = {22'h0, ACF_IDX_CLK_CTRL, 2'h0};
    localparam logic [31:0] ACF_ADDR_IRQ_STATUS = {22'h0, ACF_IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] ACF_ADDR_IRQ_MASK = {22'h0, ACF_IDX_IRQ_MASK, 2'h0};
    localparam logic [31:0] ACF_ADDR_CONV_STATUS = {22'h0, ACF_IDX_CONV_STATUS, 2'h0};

    // Reset values
    localparam logic [7:0] ACF_CLK_CTRL_RST = 8'h04;
    localparam logic [7:0] ACF_BYTE_RST = 8'h00;
    localparam logic [1:0] ACF_IRQ_RST = 2'h0;

    // Bit positions of status registers
    localparam int unsigned ACF_IRQ_STORED_BIT = 0;
    localparam int unsigned ACF_IRQ_LOST_BIT = 1;
    localparam int unsigned ACF_CONV_DONE_BIT = 0;
    localparam int unsigned ACF_CONV_LOCK_BIT = 1;

    // Bus encodings
    localparam logic [1:0] ACF_HTRANS_IDLE = 2'h0;
    localparam logic ACF_HRESP_OKAY = 1'b0;

    // Placement formats, codes as seen by software
    typedef enum logic [1:0] {
        ACF_FMT_TRUNC8 = 2'h0,
        ACF_FMT_RIGHT = 2'h1,
        ACF_FMT_LEFT = 2'h2,
        ACF_FMT_SIGNED = 2'h3
    } acf_fmt_e;

    // Clock control register layout, msb first
    typedef struct packed {
        logic [2:0] div_sel;
        logic clk_sel;
        acf_fmt_e mode;
        logic [1:0] rsvd;
    } acf_clk_ctrl_s;

    // Formatted result pair
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } acf_result_s;

    // Captured bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } acf_aphase_s;

endpackage : acf_pkg

// ### verif/acf_top_asserts.sv
// Port-level assertions of the converter result and clock block
`timescale 1ns/1ps
module acf_top_asserts
    import acf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Converter side
    input wire logic conv_done,
    input wire logic conv_single,
    input wire logic [9:0] conv_result,
    input wire logic crystal_reference_clock,
    input wire logic conv_clk_tick,
    input wire logic irq
);
    logic rd_ff;
    logic wr_ff;
    logic [31:0] wadr_ff;
    logic [7:0] ctrl_ff;
    wire logic take = hsel && hready && htrans[1];

    // Shadow of clock control, applied at the end of the write data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            wadr_ff <= 32'h0;
            ctrl_ff <= ACF_CLK_CTRL_RST;
        end
        else
        begin
            rd_ff <= take && !hwrite;
            wr_ff <= take && hwrite;
            wadr_ff <= haddr;
            if (wr_ff && wadr_ff == ACF_ADDR_CLK_CTRL)
                ctrl_ff <= hwdata[7:0];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_fast;
        ctrl_ff[7:4] == 4'h1;
    endsequence
    sequence s_slow;
        ctrl_ff[7:5] != 3'h0;
    endsequence
    // Crystal held still: no source edge can reach the divider
    sequence s_xtal_quiet;
        !ctrl_ff[4] && $stable(crystal_reference_clock);
    endsequence

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (hresp == ACF_HRESP_OKAY)
        else $error("hresp not okay");
    a_rdata_idle: assert property (!rd_ff |-> hrdata == 32'h0)
        else $error("hrdata not zero outside read");
    a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(conv_done) || $past(wr_ff) || $past(wr_ff, 2))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(irq) |->
        $past(wr_ff) || $past(wr_ff, 2))
        else $error("irq fell without write");
    a_tick_fast: assert property (s_fast [*3] |-> conv_clk_tick)
        else $error("no tick at bus clock divide 1");
    a_tick_spaced: assert property (s_slow [*3] ##0 conv_clk_tick |=> !conv_clk_tick)
        else $error("back to back ticks when dividing");
    a_xtal_quiet: assert property (s_xtal_quiet [*8] |-> !conv_clk_tick)
        else $error("tick without crystal edge");
endmodule : acf_top_asserts

bind acf_top acf_top_asserts i_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_done(conv_done), .conv_single(conv_single), .conv_result(conv_result),
    .crystal_reference_clock(crystal_reference_clock), .conv_clk_tick(conv_clk_tick),
    .irq(irq));

// ### verif/acf_top_test.sv
// Self-checking bench of the converter result and clock block
`timescale 1ns/1ps
module acf_top_test import acf_pkg::*; ;
    logic hclk, hresetn, hsel, hwrite, conv_done, conv_single, xtal, xtal_on;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata;
    logic [9:0] conv_result;
    logic [15:0] exp16;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, tick, irq;
    int err_count, tests_run, cyc, n;
    int dv[6] = '{1, 2, 4, 8, 16, 16};
    logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    acf_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .conv_done(conv_done), .conv_single(conv_single), .conv_result(conv_result),
        .crystal_reference_clock(xtal), .conv_clk_tick(tick), .irq(irq));

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Crystal runs at an eighth of hclk only while enabled; also the hang guard
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (xtal_on)
            xtal <= cyc[2];
        if (cyc == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wait_rdy;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask : wait_rdy

    task automatic phase(input logic [31:0] a, input logic w);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= ACF_HTRANS_IDLE;
    endtask : phase

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        phase(a, 1'b1);
        hwdata <= d;
        wait_rdy();
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        phase(a, 1'b0);
        wait_rdy();
        chk(hrdata, e);
    endtask : rdc

    task automatic conv(input logic [9:0] r, input logic s);
        conv_done <= 1'b1;
        conv_result <= r;
        conv_single <= s;
        @(posedge hclk);
        conv_done <= 1'b0;
        @(posedge hclk);
    endtask : conv

    task automatic count(input int cycles, input int e);
        n = 0;
        repeat (8) @(posedge hclk);
        repeat (cycles)
        begin
            @(posedge hclk);
            if (tick === 1'b1)
                n++;
        end
        chk(n, e);
    endtask : count

    function automatic logic [15:0] place(input logic [1:0] m, input logic [9:0] r);
        case (m)
            2'h0: place = {8'h00, r[9:2]};
            2'h1: place = {6'h00, r};
            2'h2: place = {r, 6'h00};
            default: place = {~r[9], r[8:0], 6'h00};
        endcase
    endfunction : place

    initial
    begin
        {hresetn, hwrite, conv_done, conv_single, xtal, xtal_on} = 6'h00;
        {err_count, tests_run} = '0;
        hsel = 1'b1;
        htrans = ACF_HTRANS_IDLE;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        conv_result = 10'h000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ACF_ADDR_RESULT_HIGH, 32'h0);
        rdc(ACF_ADDR_RESULT_LOW, 32'h0);
        rdc(ACF_ADDR_CLK_CTRL, 32'h04);
        wr(ACF_ADDR_RESULT_HIGH, 32'hFF);
        wr(32'h200, 32'hFF);
        rdc(ACF_ADDR_RESULT_HIGH, 32'h0);
        rdc(32'h200, 32'h0);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            wr(ACF_ADDR_CLK_CTRL, {24'h0, 4'h1, m[1:0], 2'h0});
            conv(10'h2C5, 1'b1);
            exp16 = place(m[1:0], 10'h2C5);
            rdc(ACF_ADDR_RESULT_HIGH, {24'h0, exp16[15:8]});
            rdc(ACF_ADDR_RESULT_LOW, {24'h0, exp16[7:0]});
        end
        $display("test formats done");
        wr(ACF_ADDR_CLK_CTRL, 32'h14);
        wr(ACF_ADDR_IRQ_STATUS, 32'h3);
        conv(10'h155, 1'b1);
        rdc(ACF_ADDR_RESULT_HIGH, 32'h01);
        conv(10'h2AA, 1'b1);
        rdc(ACF_ADDR_RESULT_LOW, 32'h55);
        rdc(ACF_ADDR_IRQ_STATUS, 32'h3);
        conv(10'h0F0, 1'b0);
        rdc(ACF_ADDR_RESULT_LOW, 32'h55);
        conv(10'h2AA, 1'b1);
        rdc(ACF_ADDR_RESULT_HIGH, 32'h02);
        rdc(ACF_ADDR_RESULT_LOW, 32'hAA);
        conv_result <= 10'h3C3;
        conv_done <= 1'b1;
        phase(ACF_ADDR_RESULT_HIGH, 1'b0);
        conv_done <= 1'b0;
        wait_rdy();
        chk(hrdata, 32'h02);
        rdc(ACF_ADDR_RESULT_LOW, 32'hAA);
        wr(ACF_ADDR_CLK_CTRL, 32'h10);
        conv(10'h155, 1'b1);
        rdc(ACF_ADDR_RESULT_HIGH, 32'h0);
        conv(10'h2AA, 1'b1);
        rdc(ACF_ADDR_RESULT_LOW, 32'hAA);
        $display("test interlock done");
        conv(10'h3FF, 1'b1);
        rdc(ACF_ADDR_CONV_STATUS, 32'h1);
        rdc(ACF_ADDR_RESULT_LOW, 32'hFF);
        rdc(ACF_ADDR_CONV_STATUS, 32'h0);
        conv(10'h3FF, 1'b1);
        wr(ACF_ADDR_CLK_CTRL, 32'h10);
        rdc(ACF_ADDR_CONV_STATUS, 32'h0);
        $display("test done flag done");
        wr(ACF_ADDR_IRQ_STATUS, 32'h3);
        wr(ACF_ADDR_IRQ_MASK, 32'h1);
        conv(10'h001, 1'b1);
        chk({31'h0, irq}, 32'h1);
        wr(ACF_ADDR_IRQ_STATUS, 32'h1);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(ACF_ADDR_IRQ_MASK, 32'h0);
        conv(10'h001, 1'b1);
        chk({31'h0, irq}, 32'h0);
        rdc(ACF_ADDR_IRQ_STATUS, 32'h1);
        $display("test interrupt done");
        for (int i = 0; i < 6; i++)
        begin
            wr(ACF_ADDR_CLK_CTRL, {24'h0, cd[i], 5'h14});
            count(64, 64 / dv[i]);
        end
        xtal_on <= 1'b1;
        wr(ACF_ADDR_CLK_CTRL, 32'h04);
        count(128, 16);
        wr(ACF_ADDR_CLK_CTRL, 32'h24);
        count(128, 8);
        xtal_on <= 1'b0;
        $display("test prescaler done");
        conclude();
    end
endmodule : acf_top_test
